// ==== rtl/vdsr_setpoint_bank.v ====
// Purpose: setpoint register bank with pin-selected voltage and mode
// Assumes: scl and sda come from pins; serial bus slave, no clock stretching
// Notes:   set of the thermal flag wins over a clear in the same cycle
`timescale 1ns/100ps
`default_nettype none
`include "vdsr_consts.vh"

module vdsr_setpoint_bank #(
	parameter       WIDE_CODE = 1,
	parameter [7:0] RST_SP0   = `VDSR_RST7_SETPOINT_0,
	parameter [7:0] RST_SP1   = `VDSR_RST7_SETPOINT_1,
	parameter [7:0] RST_SP2   = `VDSR_RST7_SETPOINT_2,
	parameter [7:0] RST_SP3   = `VDSR_RST7_SETPOINT_3,
	parameter [6:0] BUS_ADDR  = `VDSR_BUS_ADDR,
	parameter [7:0] IDENT_A   = `VDSR_IDENT_A,
	parameter [7:0] IDENT_B   = `VDSR_IDENT_B
) (
	input  wire        sys_clk,
	input  wire        rst_n,
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        sda_out,
	output wire        sda_oe_n,
	input  wire        select_pin_low,
	input  wire        select_pin_high,
	input  wire        thermal_trip,
	input  wire        thermal_early_warning,
	output reg         active_forced_pwm,
	output reg  [6:0]  active_voltage_code,
	output reg  [10:0] active_target_mv,
	output reg         enable_pin_pulldown,
	output reg         select_low_pulldown,
	output reg         select_high_pulldown,
	output reg         thermal_shutdown_disable,
	output reg         thermal_shutdown_flag,
	output reg         thermal_shutdown_active,
	output reg  [2:0]  slew_rate_code,
	output reg         output_discharge_enable,
	output reg         power_save_ramp_select,
	output reg         ramp_down_by_load
);

	localparam [3:0] S_IDLE      = 4'h0;
	localparam [3:0] S_ADDR      = 4'h1;
	localparam [3:0] S_ADDR_ACK  = 4'h2;
	localparam [3:0] S_REG       = 4'h3;
	localparam [3:0] S_REG_ACK   = 4'h4;
	localparam [3:0] S_WDATA     = 4'h5;
	localparam [3:0] S_WDATA_ACK = 4'h6;
	localparam [3:0] S_RDATA     = 4'h7;
	localparam [3:0] S_RACK      = 4'h8;
	localparam [2:0] RST_PD      = `VDSR_RST_PULLDOWN;

	reg  [5:0] sync_a;
	reg  [5:0] sync_b;
	reg        scl_d;
	reg        sda_d;
	reg  [3:0] state;
	reg  [3:0] bit_cnt;
	reg  [7:0] shift;
	reg  [7:0] tx;
	reg  [7:0] ptr;
	reg        read_dir;
	reg        drive_low;
	reg  [7:0] setpoint [0:3];
	reg  [7:0] rd_byte;
	reg  [7:0] sel_sp;
	wire       scl_s;
	wire       sda_s;
	wire       scl_rise;
	wire       scl_fall;
	wire       bus_start;
	wire       bus_stop;
	wire       wr_en;
	wire [7:0] sp_mask;

	// converts a setpoint byte to millivolts for the variant in use
	function [10:0] code_to_mv;
		input [7:0] sp;
		begin
			if (WIDE_CODE != 0) begin
				code_to_mv = `VDSR_BASE7_MV + {4'h0, sp[6:0]} * `VDSR_STEP_MV;
			end else begin
				code_to_mv = `VDSR_BASE6_MV + {5'h00, sp[5:0]} * `VDSR_STEP_MV;
			end
		end
	endfunction

	// two-stage synchronisers, then a third stage for edge detection
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			sync_a <= 6'h3C; // thermal inputs idle low, no false trip
			sync_b <= 6'h3C;
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
		end else begin
			sync_a <= {scl_in, sda_in, select_pin_low, select_pin_high,
				thermal_trip, thermal_early_warning};
			sync_b <= sync_a;
			scl_d  <= sync_b[5];
			sda_d  <= sync_b[4];
		end
	end

	assign scl_s     = sync_b[5];
	assign sda_s     = sync_b[4];
	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
	assign sda_out   = 1'b0;
	assign sda_oe_n  = ~drive_low;
	assign wr_en     = scl_fall & (state == S_WDATA) & (bit_cnt == 4'h8);
	// reserved bit 6 is not stored in the 6-bit variant
	assign sp_mask   = (WIDE_CODE != 0) ? 8'hFF : 8'hBF;

	// serial bus slave: address, register pointer, data bytes
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			state     <= S_IDLE;
			bit_cnt   <= 4'h0;
			shift     <= 8'h00;
			tx        <= 8'h00;
			ptr       <= 8'h00;
			read_dir  <= 1'b0;
			drive_low <= 1'b0;
		end else if (bus_start) begin
			state     <= S_ADDR;
			bit_cnt   <= 4'h0;
			drive_low <= 1'b0;
		end else if (bus_stop) begin
			state     <= S_IDLE;
			drive_low <= 1'b0;
		end else if (scl_rise) begin
			if ((state == S_ADDR || state == S_REG || state == S_WDATA)
				&& bit_cnt != 4'h8) begin
				shift   <= {shift[6:0], sda_s};
				bit_cnt <= bit_cnt + 4'h1;
			end else if (state == S_RACK) begin
				if (sda_s) begin
					state <= S_IDLE; // master ended the read
				end else begin
					ptr <= ptr + 8'h01;
				end
			end
		end else if (scl_fall) begin
			case (state)
				S_ADDR: begin
					if (bit_cnt == 4'h8) begin
						if (shift[7:1] == BUS_ADDR) begin
							read_dir  <= shift[0];
							drive_low <= 1'b1;
							state     <= S_ADDR_ACK;
						end else begin
							state <= S_IDLE;
						end
					end
				end
				S_REG: begin
					if (bit_cnt == 4'h8) begin
						ptr       <= shift;
						drive_low <= 1'b1;
						state     <= S_REG_ACK;
					end
				end
				S_WDATA: begin
					if (bit_cnt == 4'h8) begin
						drive_low <= 1'b1;
						state     <= S_WDATA_ACK;
					end
				end
				S_ADDR_ACK, S_RACK: begin
					if (read_dir) begin
						tx        <= rd_byte;
						drive_low <= ~rd_byte[7];
						bit_cnt   <= 4'h1;
						state     <= S_RDATA;
					end else begin
						drive_low <= 1'b0;
						bit_cnt   <= 4'h0;
						state     <= S_REG;
					end
				end
				S_REG_ACK: begin
					drive_low <= 1'b0;
					bit_cnt   <= 4'h0;
					state     <= S_WDATA;
				end
				S_WDATA_ACK: begin
					drive_low <= 1'b0;
					bit_cnt   <= 4'h0;
					ptr       <= ptr + 8'h01;
					state     <= S_WDATA;
				end
				S_RDATA: begin
					if (bit_cnt == 4'h8) begin
						drive_low <= 1'b0;
						state     <= S_RACK;
					end else begin
						tx        <= {tx[6:0], 1'b0};
						drive_low <= ~tx[6];
						bit_cnt   <= bit_cnt + 4'h1;
					end
				end
				default: begin
					drive_low <= 1'b0;
				end
			endcase
		end
	end

	// register file writes; reserved fields and slots drop the data
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			setpoint[0]              <= RST_SP0 & sp_mask;
			setpoint[1]              <= RST_SP1 & sp_mask;
			setpoint[2]              <= RST_SP2 & sp_mask;
			setpoint[3]              <= RST_SP3 & sp_mask;
			enable_pin_pulldown      <= RST_PD[2];
			select_low_pulldown      <= RST_PD[1];
			select_high_pulldown     <= RST_PD[0];
			thermal_shutdown_disable <= 1'b0;
			thermal_shutdown_flag    <= 1'b0;
			slew_rate_code           <= `VDSR_RST_SLEW;
			output_discharge_enable  <= 1'b0;
			power_save_ramp_select   <= 1'b0;
		end else begin
			if (wr_en) begin
				case (ptr)
					{4'h0, `VDSR_REG_SETPOINT_0}: setpoint[0] <= shift & sp_mask;
					{4'h0, `VDSR_REG_SETPOINT_1}: setpoint[1] <= shift & sp_mask;
					{4'h0, `VDSR_REG_SETPOINT_2}: setpoint[2] <= shift & sp_mask;
					{4'h0, `VDSR_REG_SETPOINT_3}: setpoint[3] <= shift & sp_mask;
					{4'h0, `VDSR_REG_PULLDOWN}: begin
						enable_pin_pulldown  <= shift[`VDSR_BIT_EN_PULLDOWN];
						select_low_pulldown  <= shift[`VDSR_BIT_SELLO_PULLDOWN];
						select_high_pulldown <= shift[`VDSR_BIT_SELHI_PULLDOWN];
					end
					{4'h0, `VDSR_REG_THERMAL}: begin
						thermal_shutdown_disable <= shift[`VDSR_BIT_TS_DISABLE];
					end
					{4'h0, `VDSR_REG_SLEW_RAMP}: begin
						slew_rate_code          <= shift[`VDSR_BIT_SLEW_MSB:`VDSR_BIT_SLEW_LSB];
						output_discharge_enable <= shift[`VDSR_BIT_DISCHARGE];
						power_save_ramp_select  <= shift[`VDSR_BIT_PS_RAMP];
					end
					default: begin
						thermal_shutdown_flag <= thermal_shutdown_flag;
					end
				endcase
			end
			// sticky flag: a trip beats a software clear in the same cycle
			if (sync_b[1] & ~thermal_shutdown_disable) begin
				thermal_shutdown_flag <= 1'b1;
			end else if (wr_en && ptr == {4'h0, `VDSR_REG_THERMAL}
				&& !shift[`VDSR_BIT_TS_FLAG]) begin
				thermal_shutdown_flag <= 1'b0;
			end
		end
	end

	// read mux; reserved bits, the reserved slot and unmapped read zero
	always @* begin
		rd_byte = 8'h00;
		case (ptr)
			{4'h0, `VDSR_REG_SETPOINT_0}: rd_byte = setpoint[0];
			{4'h0, `VDSR_REG_SETPOINT_1}: rd_byte = setpoint[1];
			{4'h0, `VDSR_REG_SETPOINT_2}: rd_byte = setpoint[2];
			{4'h0, `VDSR_REG_SETPOINT_3}: rd_byte = setpoint[3];
			{4'h0, `VDSR_REG_PULLDOWN}:
				rd_byte = {enable_pin_pulldown, select_low_pulldown,
					select_high_pulldown, 5'h00};
			{4'h0, `VDSR_REG_THERMAL}:
				rd_byte = {5'h00, thermal_shutdown_disable, sync_b[0],
					thermal_shutdown_flag};
			{4'h0, `VDSR_REG_SLEW_RAMP}:
				rd_byte = {slew_rate_code, 2'h0, output_discharge_enable,
					power_save_ramp_select, 1'b0};
			{4'h0, `VDSR_REG_IDENT_A}: rd_byte = IDENT_A;
			{4'h0, `VDSR_REG_IDENT_B}: rd_byte = IDENT_B;
			default: rd_byte = 8'h00;
		endcase
	end

	// pick the setpoint named by the synchronised select pins
	always @* begin
		case ({sync_b[2], sync_b[3]})
			2'h0:    sel_sp = setpoint[0];
			2'h1:    sel_sp = setpoint[1];
			2'h2:    sel_sp = setpoint[2];
			default: sel_sp = setpoint[3];
		endcase
	end

	// registered regulator controls
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			active_forced_pwm       <= 1'b0;
			active_voltage_code     <= 7'h00;
			active_target_mv        <= 11'h000;
			thermal_shutdown_active <= 1'b0;
			ramp_down_by_load       <= 1'b0;
		end else begin
			active_forced_pwm       <= sel_sp[`VDSR_BIT_OPMODE];
			active_voltage_code     <= (WIDE_CODE != 0) ? sel_sp[6:0] : {1'b0, sel_sp[5:0]};
			active_target_mv        <= code_to_mv(sel_sp);
			thermal_shutdown_active <= thermal_shutdown_flag & ~thermal_shutdown_disable;
			ramp_down_by_load       <= ~sel_sp[`VDSR_BIT_OPMODE] & ~power_save_ramp_select;
		end
	end

endmodule // vdsr_setpoint_bank
`default_nettype wire

// ==== shared/vdsr_consts.vh ====
// Purpose: constants for the voltage setpoint register bank
// Assumes: byte-wide registers reached over a two-wire serial bus
// Notes:   reset values of the 7-bit code variant come first
`ifndef VDSR_CONSTS_VH
`define VDSR_CONSTS_VH

// register offsets
`define VDSR_REG_SETPOINT_0     4'h0
`define VDSR_REG_SETPOINT_1     4'h1
`define VDSR_REG_SETPOINT_2     4'h2
`define VDSR_REG_SETPOINT_3     4'h3
`define VDSR_REG_PULLDOWN       4'h4
`define VDSR_REG_THERMAL        4'h5
`define VDSR_REG_SLEW_RAMP      4'h6
`define VDSR_REG_RESERVED       4'h7
`define VDSR_REG_IDENT_A        4'h8
`define VDSR_REG_IDENT_B        4'h9

// field positions
`define VDSR_BIT_OPMODE         7
`define VDSR_BIT_CODE_MSB7      6
`define VDSR_BIT_EN_PULLDOWN    7
`define VDSR_BIT_SELLO_PULLDOWN 6
`define VDSR_BIT_SELHI_PULLDOWN 5
`define VDSR_BIT_TS_DISABLE     2
`define VDSR_BIT_EARLY_WARN     1
`define VDSR_BIT_TS_FLAG        0
`define VDSR_BIT_SLEW_MSB       7
`define VDSR_BIT_SLEW_LSB       5
`define VDSR_BIT_DISCHARGE      2
`define VDSR_BIT_PS_RAMP        1

// reset values, 7-bit code variant
`define VDSR_RST7_SETPOINT_0    8'h2E
`define VDSR_RST7_SETPOINT_1    8'h5A
`define VDSR_RST7_SETPOINT_2    8'h42
`define VDSR_RST7_SETPOINT_3    8'h42
// reset values, 6-bit code variant with 1.23 V first preset
`define VDSR_RST6_SETPOINT_0    8'h2E
`define VDSR_RST6_SETPOINT_1    8'h17
`define VDSR_RST6_SETPOINT_2    8'h2B
`define VDSR_RST6_SETPOINT_3    8'h21
`define VDSR_RST_PULLDOWN       3'h7
`define VDSR_RST_SLEW           3'h0

// voltage scaling in millivolts
`define VDSR_STEP_MV            11'h00A
`define VDSR_BASE6_MV           11'h302
`define VDSR_BASE7_MV           11'h1F4

// serial bus slave address and identification bytes (arbitrary values)
`define VDSR_BUS_ADDR           7'h4C
`define VDSR_IDENT_A            8'h5A
`define VDSR_IDENT_B            8'hC3

`endif

// ==== tb/vdsr_host_model.sv ====
// Purpose: host side, two-wire bus master with open-drain data
// Assumes: pull-up on data, clock high six system clocks, low twelve
// Notes:   data bits move only mid low phase; start and stop move data with the clock high
`timescale 1ns/100ps
`default_nettype none
`include "vdsr_consts.vh"

module vdsr_host_model (
	input  wire logic sys_clk,
	input  wire logic sda,
	output var  logic scl,
	output var  logic sda_m
);
	// bus idle at time zero
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic hp; repeat (6) @(posedge sys_clk); #1; endtask
	task automatic bitx(input logic b, output logic r);
		hp; sda_m = b; hp; scl = 1'b1; hp; r = sda; scl = 1'b0;
	endtask
	task automatic start; sda_m = 1'b1; hp; scl = 1'b1; hp; sda_m = 1'b0; hp; scl = 1'b0; endtask
	task automatic stop; hp; sda_m = 1'b0; hp; scl = 1'b1; hp; sda_m = 1'b1; hp; endtask
	// byte msb first then the acknowledge bit
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(ak, a);
	endtask
	task automatic wr(input logic [6:0] dv, input logic [7:0] a, d, output logic nk);
		logic [7:0] q;
		logic n0, n1, n2;
		start; xfer({dv, 1'b0}, 1'b1, q, n0); xfer(a, 1'b1, q, n1);
		xfer(d, 1'b1, q, n2); stop; nk = n0 | n1 | n2;
	endtask
	task automatic rd(input logic [6:0] dv, input logic [7:0] a, output logic [7:0] d,
		output logic nk);
		logic [7:0] q;
		logic n0, n1, n2, n3;
		start; xfer({dv, 1'b0}, 1'b1, q, n0); xfer(a, 1'b1, q, n1); start;
		xfer({dv, 1'b1}, 1'b1, q, n2); xfer(8'hFF, 1'b1, d, n3); stop; nk = n0 | n1 | n2;
	endtask
endmodule // vdsr_host_model
`default_nettype wire

// ==== tb/vdsr_setpoint_bank_tb_top.sv ====
// Purpose: self-checking bench for the setpoint register bank
// Assumes: 7-bit code variant, 40 MHz clock
// Notes:   expectations queued by the driver, compared by a monitor
`timescale 1ns/100ps
`default_nettype none
`include "vdsr_consts.vh"

module vdsr_setpoint_bank_tb_top;
	localparam logic [6:0] DEV = `VDSR_BUS_ADDR;
	localparam WIDE_CODE = 1;
	logic        sys_clk, rst_n, scl_in, sda_in, sda_out, sda_oe_n, sda_m, nk;
	logic        select_pin_low, select_pin_high, thermal_trip, thermal_early_warning;
	logic        active_forced_pwm, enable_pin_pulldown, select_low_pulldown;
	logic        select_high_pulldown, thermal_shutdown_disable, thermal_shutdown_flag;
	logic        thermal_shutdown_active, output_discharge_enable, power_save_ramp_select;
	logic        ramp_down_by_load;
	logic [6:0]  active_voltage_code;
	logic [10:0] active_target_mv;
	logic [2:0]  slew_rate_code;
	logic [7:0]  q, sp [4], rv [10];
	logic [10:0] exp_q [$], seen_q [$];
	int          err_count = 0, check_count = 0;
	// open-drain data wire with pull-up
	assign sda_in = sda_m & (sda_oe_n | sda_out);
	vdsr_setpoint_bank #(.WIDE_CODE(WIDE_CODE)) u_vdsr_setpoint_bank (
		.sys_clk                  (sys_clk),
		.rst_n                    (rst_n),
		.scl_in                   (scl_in),
		.sda_in                   (sda_in),
		.sda_out                  (sda_out),
		.sda_oe_n                 (sda_oe_n),
		.select_pin_low           (select_pin_low),
		.select_pin_high          (select_pin_high),
		.thermal_trip             (thermal_trip),
		.thermal_early_warning    (thermal_early_warning),
		.active_forced_pwm        (active_forced_pwm),
		.active_voltage_code      (active_voltage_code),
		.active_target_mv         (active_target_mv),
		.enable_pin_pulldown      (enable_pin_pulldown),
		.select_low_pulldown      (select_low_pulldown),
		.select_high_pulldown     (select_high_pulldown),
		.thermal_shutdown_disable (thermal_shutdown_disable),
		.thermal_shutdown_flag    (thermal_shutdown_flag),
		.thermal_shutdown_active  (thermal_shutdown_active),
		.slew_rate_code           (slew_rate_code),
		.output_discharge_enable  (output_discharge_enable),
		.power_save_ramp_select   (power_save_ramp_select),
		.ramp_down_by_load        (ramp_down_by_load)
	);
	vdsr_host_model u_vdsr_host_model (.sys_clk(sys_clk), .sda(sda_in), .scl(scl_in),
		.sda_m(sda_m));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic tick(input int n); repeat (n) @(posedge sys_clk); #1; endtask
	task automatic chk(input logic [10:0] s, e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic note(input logic [10:0] s, e); exp_q.push_back(e); seen_q.push_back(s); endtask
	task automatic wr(input logic [7:0] a, d); u_vdsr_host_model.wr(DEV, a, d, nk); note(nk, 0); endtask
	task automatic rdc(input logic [7:0] a, e);
		u_vdsr_host_model.rd(DEV, a, q, nk); note(nk, 0); note(q, e);
	endtask
	task automatic act(input logic h, l, input logic [7:0] v);
		select_pin_high = h; select_pin_low = l; tick(6);
		note(active_voltage_code, v[6:0]); note(active_forced_pwm, v[7]);
		note(active_target_mv, {4'h0, v[6:0]} * 11'h00A + 11'h1F4);
	endtask
	task automatic complete_run;
		#1 $display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// monitor takes the oldest note whenever a result appears
	initial forever begin
		wait (seen_q.size() > 0);
		chk(seen_q.pop_front(), exp_q.pop_front());
	end
	// watchdog
	initial begin
		repeat (90000) @(posedge sys_clk);
		err_count++;
		complete_run;
	end
	// main sequence
	initial begin
		rst_n = 0; select_pin_low = 0; select_pin_high = 0; thermal_trip = 0;
		thermal_early_warning = 0;
		rv = '{8'h2E, 8'h5A, 8'h42, 8'h42, 8'hE0, 8'h00, 8'h00, 8'h00, `VDSR_IDENT_A, `VDSR_IDENT_B};
		tick(10); rst_n = 1; tick(4);
		void'($urandom(32'h69F32990));
		for (int i = 0; i < 10; i++) rdc(i[7:0], rv[i]);
		for (int i = 0; i < 4; i++) act(i[1], i[0], rv[i]);
		$display("test reset and select done");
		for (int i = 0; i < 4; i++) begin
			sp[i] = 8'($urandom); wr(i[7:0], sp[i]); rdc(i[7:0], sp[i]);
		end
		for (int i = 0; i < 4; i++) act(i[1], i[0], sp[i]);
		wr(8'h06, 8'hFF); rdc(8'h06, 8'hE6); note(slew_rate_code, 3'h7);
		note(output_discharge_enable, 1); note(power_save_ramp_select, 1);
		note(ramp_down_by_load, 0); wr(8'h06, 8'h00); tick(4);
		note(ramp_down_by_load, !sp[3][7]);
		wr(8'h07, 8'hFF); rdc(8'h07, 8'h00); wr(8'h08, 8'h00); rdc(8'h08, `VDSR_IDENT_A);
		wr(8'h04, 8'h1F); rdc(8'h04, 8'h00); note(enable_pin_pulldown, 0);
		note(select_low_pulldown, 0); note(select_high_pulldown, 0);
		u_vdsr_host_model.wr(~DEV, 8'h00, 8'h7F, nk); note(nk, 1); rdc(8'h00, sp[0]);
		$display("test registers done");
		thermal_early_warning = 1; thermal_trip = 1; tick(8); thermal_trip = 0; tick(8);
		note(thermal_shutdown_flag, 1); note(thermal_shutdown_active, 1);
		rdc(8'h05, 8'h03); thermal_early_warning = 0; wr(8'h05, 8'h00);
		note(thermal_shutdown_flag, 0); wr(8'h05, 8'h04); note(thermal_shutdown_disable, 1);
		thermal_trip = 1; tick(8); note(thermal_shutdown_flag, 0); thermal_trip = 0;
		wr(8'h05, 8'h00); note(thermal_shutdown_disable, 0);
		$display("test thermal done");
		complete_run;
	end
endmodule // vdsr_setpoint_bank_tb_top

bind vdsr_setpoint_bank vdsr_sva #(.WIDE_CODE(WIDE_CODE)) u_vdsr_sva (
	.sys_clk                  (sys_clk),
	.rst_n                    (rst_n),
	.scl_in                   (scl_in),
	.sda_oe_n                 (sda_oe_n),
	.thermal_trip             (thermal_trip),
	.select_pin_low           (select_pin_low),
	.select_pin_high          (select_pin_high),
	.active_forced_pwm        (active_forced_pwm),
	.active_voltage_code      (active_voltage_code),
	.active_target_mv         (active_target_mv),
	.enable_pin_pulldown      (enable_pin_pulldown),
	.thermal_shutdown_disable (thermal_shutdown_disable),
	.thermal_shutdown_flag    (thermal_shutdown_flag),
	.thermal_shutdown_active  (thermal_shutdown_active),
	.slew_rate_code           (slew_rate_code),
	.power_save_ramp_select   (power_save_ramp_select),
	.ramp_down_by_load        (ramp_down_by_load)
);
`default_nettype wire

// ==== tb/vdsr_sva.sv ====
// Purpose: port checks for the setpoint register bank
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from the testbench top file
`timescale 1ns/100ps
`default_nettype none

module vdsr_sva #(
	parameter WIDE_CODE = 1
) (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        scl_in,
	input wire logic        sda_oe_n,
	input wire logic        thermal_trip,
	input wire logic        select_pin_low,
	input wire logic        select_pin_high,
	input wire logic        active_forced_pwm,
	input wire logic [6:0]  active_voltage_code,
	input wire logic [10:0] active_target_mv,
	input wire logic        enable_pin_pulldown,
	input wire logic        thermal_shutdown_disable,
	input wire logic        thermal_shutdown_flag,
	input wire logic        thermal_shutdown_active,
	input wire logic [2:0]  slew_rate_code,
	input wire logic        power_save_ramp_select,
	input wire logic        ramp_down_by_load
);
	localparam int BASE = WIDE_CODE ? 11'h1F4 : 11'h302;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// step sequences
	sequence s_code_held; $stable(active_voltage_code)[*3]; endsequence
	sequence s_quiet; (scl_in && $stable({select_pin_high, select_pin_low}))[*8]; endsequence
	sequence s_trip_held; (thermal_trip && !thermal_shutdown_disable)[*4]; endsequence
	// properties
	property p_target_mv;
		s_code_held |-> active_target_mv == active_voltage_code * 11'h00A + BASE;
	endproperty
	property p_active_hold;
		s_quiet |-> $stable(active_voltage_code) && $stable(active_forced_pwm);
	endproperty
	property p_ramp_load;
		$past(rst_n) |-> ramp_down_by_load ==
			(!active_forced_pwm && !$past(power_save_ramp_select));
	endproperty
	property p_ts_active;
		$past(rst_n) |-> thermal_shutdown_active ==
			($past(thermal_shutdown_flag) && !$past(thermal_shutdown_disable));
	endproperty
	property p_flag_set; s_trip_held |-> ##[0:3] thermal_shutdown_flag; endproperty
	property p_flag_blocked;
		thermal_shutdown_disable[*5] |-> !$rose(thermal_shutdown_flag);
	endproperty
	property p_flag_sticky;
		$fell(thermal_shutdown_flag) |-> !sda_oe_n; // clear lands with the data ack
	endproperty
	property p_reset_vals;
		$rose(rst_n) |-> enable_pin_pulldown && !thermal_shutdown_disable &&
			slew_rate_code == 3'h0 && !thermal_shutdown_flag;
	endproperty
	a_target_mv: assert property (p_target_mv)
		else $error("target millivolts disagree with code");
	a_active_hold: assert property (p_active_hold)
		else $error("active setpoint moved without a cause");
	a_ramp_load: assert property (p_ramp_load)
		else $error("ramp down by load wrong");
	a_ts_active: assert property (p_ts_active)
		else $error("shutdown active wrong");
	a_flag_set: assert property (p_flag_set)
		else $error("shutdown flag not set by trip");
	a_flag_blocked: assert property (p_flag_blocked)
		else $error("shutdown flag set while disabled");
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("shutdown flag cleared without a write");
	a_reset_vals: assert property (p_reset_vals)
		else $error("control outputs wrong after reset");
endmodule // vdsr_sva
`default_nettype wire
